// ---- rtl/tkc_control.v ----
// Summary of operation
// - Counter runs only while run enable, bit 7 of control A, is set.
// - Drift correction applies only while control A bit 1 is set.
// - Control A is write protected; device honours protection state.
// - Clock config: first write only in normal mode, any in special.
// - Source select 00 main, 01 watch crystal, 10 1 MHz, 11 reserved.
// - Main oscillator divided by divider field (bits 3:0) plus one.
// - Prescaled 1 MHz clock is divided by 32 for the counter tick.
// - Key field bits 7:6 of protect register are write only, read 0.
// - After any reset protection is off; the clock config write-once lock clears only on power-on.
// - Two consecutive key writes of 10 turn protection on.
// - Key writes 00, 01, 11, 10 in order turn protection off.
// - In debug freeze, halt bit 3 at 0 keeps counting, 1 halts.
// - Calibration out: source clock when bit 1 is 0, 1 Hz when 1.
// - Hour flag with hour enable (bit 5) raises interrupt request.
// - Minute flag with minute enable (bit 4) raises interrupt.
// - Second flag with second enable (bit 3) raises interrupt.
// - Correction flag with correction enable (bit 2) raises interrupt.
// - Quarter second flag with enable bit 0 raises interrupt.
// - Halt bit matters only while debug freeze is active.
// - Flags set on events, cleared by writing 1; writing 0 no effect.
// - Protect, enable and status use normal reset; others power-on.
`timescale 1ns/100ps
`include "tkc_regs.vh"
module tkc_control (
    // Clock, resets, enable
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        por_resetn,
    input  wire        clk_en,
    // AXI4-Lite write address and data
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    // Clock pins and mode inputs
    input  wire        main_oscillator_clock,
    input  wire        watch_crystal_clock,
    input  wire        internal_1mhz_clock,
    input  wire        one_hz_comp_clock,
    input  wire        special_mode,
    input  wire        debug_freeze,
    // Events from the counter and calendar
    input  wire        hour_event,
    input  wire        minute_event,
    input  wire        second_event,
    input  wire        correction_event,
    input  wire        quarter_second_event,
    // Outputs to the counter and the chip
    output wire        counter_run_enable,
    output wire        drift_correction_enable,
    output wire        counter_tick,
    output wire        counter_source_clock,
    output wire        calibration_output_clock,
    output wire        irq
);
    // Protection sequencer states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_P1   = 3'h1;
    localparam [2:0] ST_U1   = 3'h2;
    localparam [2:0] ST_U2   = 3'h3;
    localparam [2:0] ST_U3   = 3'h4;

    wire       norm_rst = ~aresetn | ~por_resetn;
    wire       por_rst  = ~por_resetn;
    reg  [7:0] ctl_a_reg;
    reg  [1:0] src_reg;
    reg  [3:0] div_reg;
    reg        cfg_written_reg;
    reg        halt_reg;
    reg        calib_output_select_reg;
    reg  [7:0] irq_en_reg;
    reg  [7:0] flag_reg;
    reg        prot_reg;
    reg  [2:0] seq_reg;
    reg  [2:0] seq_next;
    reg        prot_next;
    reg        aw_free_reg;
    reg  [7:0] aw_addr_reg;
    reg        w_free_reg;
    reg  [7:0] w_data_reg;
    reg        w_strb_reg;
    reg        bvalid_reg;
    reg  [1:0] bresp_reg;
    reg        rvalid_reg;
    reg  [7:0] rbyte_reg;
    reg  [1:0] rresp_reg;
    reg        ar_free_reg;
    reg  [3:0] pre_cnt_reg;
    reg  [4:0] div32_reg;
    reg        tick_reg;
    reg        src_clk_reg;
    reg        cal_clk_reg;
    reg        irq_reg;

    wire [3:0] pin_lvl;
    wire [3:0] pin_rise;
    // Pin synchronisers
    tkc_sync #(
        .W    (4)
    ) u_sync (
        .aclk  (aclk),
        .srst  (norm_rst),
        .ce    (clk_en),
        .din   ({one_hz_comp_clock, internal_1mhz_clock,
                 watch_crystal_clock, main_oscillator_clock}),
        .level (pin_lvl),
        .rise  (pin_rise)
    );
    // Bus write decode
    wire       wr_go   = ~aw_free_reg & ~w_free_reg & ~bvalid_reg;
    wire [5:0] wr_idx  = aw_addr_reg[7:2];
    wire       wr_en   = wr_go & w_strb_reg;
    wire       wr_ctla = wr_en & (wr_idx == `TKC_IDX_CTL_A);
    wire       wr_cfg  = wr_en & (wr_idx == `TKC_IDX_CLK_CFG);
    wire       wr_prot = wr_en & (wr_idx == `TKC_IDX_PROT_DBG);
    wire       wr_ien  = wr_en & (wr_idx == `TKC_IDX_IRQ_EN);
    wire       wr_stat = wr_en & (wr_idx == `TKC_IDX_STATUS);
    wire       wr_map  = (wr_idx <= `TKC_IDX_STATUS);
    wire [1:0] key     = w_data_reg[`TKC_KEY_HI:`TKC_KEY_LO];
    wire [5:0] rd_idx  = s_axi_araddr[7:2];
    // Write address and data channels, taken in either order
    always @(posedge aclk) begin
        if (norm_rst) begin
            aw_free_reg <= 1'b1;
            aw_addr_reg <= `TKC_RST_BYTE;
            w_free_reg  <= 1'b1;
            w_data_reg  <= `TKC_RST_BYTE;
            w_strb_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `TKC_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid & aw_free_reg) begin
                aw_free_reg <= 1'b0;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & w_free_reg) begin
                w_free_reg <= 1'b0;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                // Protected drops still answer OKAY
                bresp_reg  <= wr_map ? `TKC_RESP_OKAY
                                     : `TKC_RESP_DECERR;
            end else if (bvalid_reg & s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                aw_free_reg <= 1'b1;
                w_free_reg  <= 1'b1;
            end
        end
    end

    // Read channel, one read in flight
    always @(posedge aclk) begin
        if (norm_rst) begin
            rvalid_reg  <= 1'b0;
            ar_free_reg <= 1'b1;
            rbyte_reg   <= `TKC_RST_BYTE;
            rresp_reg   <= `TKC_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid & ar_free_reg) begin
                rvalid_reg  <= 1'b1;
                ar_free_reg <= 1'b0;
                rresp_reg  <= `TKC_RESP_OKAY;
                case (rd_idx)
                    `TKC_IDX_CTL_A:    rbyte_reg <= ctl_a_reg;
                    `TKC_IDX_CLK_CFG:  rbyte_reg <= {src_reg, 2'b00, div_reg};
                    `TKC_IDX_PROT_DBG: rbyte_reg <= {4'h0, halt_reg, 1'b0,
                                         calib_output_select_reg, 1'b0}; // Key 0
                    `TKC_IDX_IRQ_EN:   rbyte_reg <= irq_en_reg;
                    `TKC_IDX_STATUS:   rbyte_reg <= flag_reg;
                    default: begin
                        rbyte_reg <= `TKC_RST_BYTE;
                        rresp_reg <= `TKC_RESP_DECERR;
                    end
                endcase
            end else if (rvalid_reg & s_axi_rready) begin
                rvalid_reg  <= 1'b0;
                ar_free_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Power-on-only registers
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (por_rst) begin
            ctl_a_reg       <= `TKC_RST_BYTE;
            src_reg         <= `TKC_RST_SRC;
            div_reg         <= `TKC_RST_DIV;
            cfg_written_reg <= 1'b0;
        end else if (clk_en) begin
            // Dropped silently while protected
            if (wr_ctla & ~prot_reg) begin
                ctl_a_reg <= w_data_reg & {1'b1, 5'h00, 1'b1, 1'b0};
            end
            // One write in normal mode, unlimited in special mode
            if (wr_cfg & (special_mode | ~cfg_written_reg)) begin
                src_reg         <= w_data_reg[`TKC_SRC_HI:`TKC_SRC_LO];
                div_reg         <= w_data_reg[`TKC_DIV_HI:`TKC_DIV_LO];
                cfg_written_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Normal-reset registers and event flags
    // ------------------------------------------------------------
    wire [7:0] ev_vec = {2'b00, hour_event, minute_event, second_event,
                         correction_event, 1'b0, quarter_second_event};

    always @(posedge aclk) begin
        if (norm_rst) begin
            halt_reg   <= 1'b0;
            calib_output_select_reg   <= 1'b0;
            irq_en_reg <= `TKC_RST_BYTE;
            flag_reg   <= `TKC_RST_BYTE;
        end else if (clk_en) begin
            if (wr_prot) begin
                halt_reg <= w_data_reg[`TKC_BIT_HALT];
                calib_output_select_reg <= w_data_reg[`TKC_BIT_CALIB_OUTPUT_SELECT];
            end
            if (wr_ien)
                irq_en_reg <= w_data_reg & `TKC_FLAG_MASK;
            // Write 1 clears, a new event in the same cycle wins
            flag_reg <= ((flag_reg & ~({8{wr_stat}} & w_data_reg))
                         | ev_vec) & `TKC_FLAG_MASK;
        end
    end

    // Protection key sequencer
    always @* begin
        seq_next  = seq_reg;
        prot_next = prot_reg;
        if (wr_prot) begin
            case (seq_reg)
                ST_IDLE: begin
                    if (~prot_reg & (key == `TKC_KEY_10))
                        seq_next = ST_P1;
                    else if (prot_reg & (key == `TKC_KEY_00))
                        seq_next = ST_U1;
                end
                ST_P1: begin
                    seq_next = ST_IDLE;
                    if (key == `TKC_KEY_10)
                        prot_next = 1'b1;
                end
                ST_U1: begin
                    if (key == `TKC_KEY_01)
                        seq_next = ST_U2;
                    else if (key != `TKC_KEY_00)
                        seq_next = ST_IDLE;
                end
                ST_U2: begin
                    if (key == `TKC_KEY_11)
                        seq_next = ST_U3;
                    else if (key == `TKC_KEY_00)
                        seq_next = ST_U1;
                    else
                        seq_next = ST_IDLE;
                end
                ST_U3: begin
                    if (key == `TKC_KEY_10) begin
                        seq_next  = ST_IDLE;
                        prot_next = 1'b0;
                    end else if (key == `TKC_KEY_00) begin
                        seq_next = ST_U1;
                    end else begin
                        seq_next = ST_IDLE;
                    end
                end
                default: seq_next = ST_IDLE;
            endcase
        end
    end

    // Protection cleared by any reset
    always @(posedge aclk) begin
        if (norm_rst) begin
            prot_reg <= 1'b0;
            seq_reg  <= ST_IDLE;
        end else if (clk_en) begin
            prot_reg <= prot_next;
            seq_reg  <= seq_next;
        end
    end

    // ------------------------------------------------------------
    // Source selection, prescaler and divide by 32
    // ------------------------------------------------------------
    wire main_sel  = (src_reg == `TKC_SRC_MAIN);
    wire pre_wrap  = main_sel & pin_rise[0] & (pre_cnt_reg == div_reg);
    wire mhz_tick  = pre_wrap | ((src_reg == `TKC_SRC_IRC) & pin_rise[2]);
    wire div_wrap  = mhz_tick & (div32_reg == `TKC_DIV32_LAST);
    wire raw_tick  = div_wrap | ((src_reg == `TKC_SRC_WATCH) & pin_rise[1]);
    wire frozen    = debug_freeze & halt_reg;
    wire run       = ctl_a_reg[`TKC_BIT_RUN];
    reg  src_lvl;

    // Level of the selected source, reserved code gives none
    always @* begin
        case (src_reg)
            `TKC_SRC_MAIN:  src_lvl = pin_lvl[0];
            `TKC_SRC_WATCH: src_lvl = pin_lvl[1];
            `TKC_SRC_IRC:   src_lvl = pin_lvl[2];
            default:        src_lvl = 1'b0;
        endcase
    end

    // Divider counters and registered outputs
    always @(posedge aclk) begin
        if (norm_rst) begin
            pre_cnt_reg <= `TKC_RST_DIV;
            div32_reg   <= `TKC_RST_DIV32;
            tick_reg    <= 1'b0;
            src_clk_reg <= 1'b0;
            cal_clk_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end else if (clk_en) begin
            if (main_sel & pin_rise[0])
                pre_cnt_reg <= pre_wrap ? `TKC_RST_DIV
                                        : pre_cnt_reg + 4'h1;
            if (mhz_tick)
                div32_reg <= div32_reg + 5'h01;
            tick_reg    <= raw_tick & run & ~frozen;
            src_clk_reg <= src_lvl;
            cal_clk_reg <= calib_output_select_reg ? pin_lvl[3] : src_lvl;
            irq_reg <= |(flag_reg & irq_en_reg);
            // Same reduction
        end
    end

    // ------------------------------------------------------------
    // Output assignments
    // ------------------------------------------------------------
    assign s_axi_awready            = aw_free_reg;
    assign s_axi_wready             = w_free_reg;
    assign s_axi_bvalid             = bvalid_reg;
    assign s_axi_bresp              = bresp_reg;
    assign s_axi_arready            = ar_free_reg;
    assign s_axi_rvalid             = rvalid_reg;
    assign s_axi_rresp              = rresp_reg;
    assign s_axi_rdata              = {`TKC_PAD_ZERO, rbyte_reg};
    assign counter_run_enable       = ctl_a_reg[`TKC_BIT_RUN];
    assign drift_correction_enable  = ctl_a_reg[`TKC_BIT_DRIFT];
    assign counter_tick             = tick_reg;
    assign counter_source_clock     = src_clk_reg;
    assign calibration_output_clock = cal_clk_reg;
    assign irq                      = irq_reg;
endmodule

// ---- rtl/tkc_regs.vh ----
`ifndef TKC_REGS_VH
`define TKC_REGS_VH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TKC_IDX_CTL_A        6'h00
`define TKC_IDX_CLK_CFG      6'h01
`define TKC_IDX_PROT_DBG     6'h02
`define TKC_IDX_IRQ_EN       6'h03
`define TKC_IDX_STATUS       6'h04
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TKC_BIT_RUN          7
`define TKC_BIT_DRIFT        1
`define TKC_SRC_HI           7
`define TKC_SRC_LO           6
`define TKC_DIV_HI           3
`define TKC_DIV_LO           0
`define TKC_KEY_HI           7
`define TKC_KEY_LO           6
`define TKC_BIT_HALT         3
`define TKC_BIT_CALIB_OUTPUT_SELECT         1
`define TKC_BIT_HOUR         5
`define TKC_BIT_MIN          4
`define TKC_BIT_SEC          3
`define TKC_BIT_CORR         2
`define TKC_BIT_QTR          0
// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define TKC_RST_BYTE         8'h00
`define TKC_RST_SRC          2'h0
`define TKC_RST_DIV          4'h0
`define TKC_RST_DIV32        5'h00
`define TKC_DIV32_LAST       5'h1f
`define TKC_SRC_MAIN         2'h0
`define TKC_SRC_WATCH        2'h1
`define TKC_SRC_IRC          2'h2
`define TKC_KEY_00           2'h0
`define TKC_KEY_01           2'h1
`define TKC_KEY_11           2'h3
`define TKC_KEY_10           2'h2
`define TKC_FLAG_MASK        8'h3d
`define TKC_RESP_OKAY        2'h0
`define TKC_RESP_DECERR      2'h3
`define TKC_PAD_ZERO         24'h00_0000
`endif

// ---- rtl/tkc_sync.v ----
`timescale 1ns/100ps
module tkc_sync #(
    parameter W = 3
) (
    // Clocking
    input  wire         aclk,
    input  wire         srst,
    input  wire         ce,
    // Pins and filtered view
    input  wire [W-1:0] din,
    output wire [W-1:0] level,
    output wire [W-1:0] rise
);
    genvar i;
    // ------------------------------------------------------------
    // Three-stage sampling, change accepted when stages 2 and 3 agree
    // ------------------------------------------------------------
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg lvl_reg;
            reg rise_reg;
            always @(posedge aclk) begin
                if (srst) begin
                    s1_reg   <= 1'b0;
                    s2_reg   <= 1'b0;
                    s3_reg   <= 1'b0;
                    lvl_reg  <= 1'b0;
                    rise_reg <= 1'b0;
                end else if (ce) begin
                    s1_reg   <= din[i];
                    s2_reg   <= s1_reg;
                    s3_reg   <= s2_reg;
                    if (s2_reg == s3_reg)
                        lvl_reg <= s3_reg;
                    rise_reg <= (s2_reg == s3_reg) & s3_reg & ~lvl_reg;
                end
            end
            assign level[i] = lvl_reg;
            assign rise[i]  = rise_reg;
        end
    endgenerate
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    reg         aclk, aresetn, por_resetn, clk_en, special_mode;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata;
    reg  [3:0]  s_axi_wstrb;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready, debug_freeze;
    reg         main_oscillator_clock, watch_crystal_clock;
    reg         internal_1mhz_clock, one_hz_comp_clock;
    reg  [4:0]  ev;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire        s_axi_arready, s_axi_rvalid, irq, counter_tick;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        counter_run_enable, drift_correction_enable;
    wire        counter_source_clock, calibration_output_clock;
    integer     errors, n_checks, i, c;
    reg  [31:0] rd_data;
    reg  [1:0]  rd_resp;
    reg  [7:0]  m;
    // Design under test
    tkc_control tkc_control_i (.*, .hour_event(ev[0]),
        .minute_event(ev[1]), .second_event(ev[2]),
        .correction_event(ev[3]), .quarter_second_event(ev[4]));
    // Bus clock and 1 MHz pin
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        internal_1mhz_clock = 1'b0;
        forever #500 internal_1mhz_clock = ~internal_1mhz_clock;
    end
    // ----------
    // Bus and compare tasks
    // ----------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr  <= a;
            s_axi_wdata   <= {24'h00_0000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            chk(s_axi_bresp, 0);
            s_axi_bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] exp);
        begin
            rd(a);
            chk(rd_data, exp);
            chk(rd_resp, 0);
        end
    endtask
    task key(input [1:0] v);
        wr(8'h08, {v, 6'h00});
    endtask
    // Ticks over 1000 cycles
    task cnt(output integer n);
        integer k;
        begin
            n = 0;
            repeat (20) @(posedge aclk);
            for (k = 0; k < 1000; k = k + 1) begin
                @(posedge aclk);
                if (counter_tick === 1'b1) n = n + 1;
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // ----------
    // Scenarios
    // ----------
    task t_reset;
        begin
            for (i = 0; i < 5; i = i + 1) rchk(i * 4, 0);
            rd(8'h20);
            chk(rd_resp, 3);
            chk(rd_data, 0);
            $display("test reset done");
        end
    endtask
    task t_protect;
        begin
            wr(8'h00, 8'h82);
            chk(counter_run_enable, 1);
            chk(drift_correction_enable, 1);
            key(2);
            key(2);
            wr(8'h00, 8'h00);
            rchk(8'h00, 32'h0000_0082);
            rd(8'h08);
            chk(rd_data[7:6], 0);
            key(0);
            key(1);
            key(3);
            key(1);
            key(2);
            wr(8'h00, 8'h00);
            rchk(8'h00, 32'h0000_0082);
            key(0);
            key(1);
            key(3);
            key(2);
            wr(8'h00, 8'h02);
            rchk(8'h00, 32'h0000_0002);
            chk(counter_run_enable, 0);
            key(2);
            key(2);
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            rchk(8'h00, 32'h0000_0002);
            wr(8'h00, 8'h80);
            rchk(8'h00, 32'h0000_0080);
            $display("test protect done");
        end
    endtask
    task t_cfg;
        begin
            wr(8'h04, 8'h4f);
            wr(8'h04, 8'h80);
            rchk(8'h04, 32'h0000_004f);
            special_mode <= 1'b1;
            wr(8'h04, 8'h80);
            rchk(8'h04, 32'h0000_0080);
            special_mode <= 1'b0;
            $display("test config done");
        end
    endtask
    task t_tick;
        begin
            while (counter_tick !== 1'b1) @(posedge aclk);
            c = 0;
            do begin
                @(posedge aclk);
                c = c + 1;
            end while (counter_tick !== 1'b1);
            chk(c >= 799 && c <= 801, 1);
            wr(8'h08, 8'h08);
            debug_freeze <= 1'b1;
            cnt(c);
            chk(c, 0);
            wr(8'h08, 8'h00);
            cnt(c);
            chk(c > 0, 1);
            debug_freeze <= 1'b0;
            wr(8'h08, 8'h08);
            cnt(c);
            chk(c > 0, 1);
            wr(8'h00, 8'h00);
            cnt(c);
            chk(c, 0);
            $display("test tick done");
        end
    endtask
    task t_irq;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                m = (i == 4) ? 8'h01 : (8'h20 >> i);
                wr(8'h0c, 8'h00);
                ev[i] <= 1'b1;
                @(posedge aclk);
                ev <= 5'h00;
                repeat (3) @(posedge aclk);
                chk(irq, 0);
                rchk(8'h10, m);
                wr(8'h0c, m);
                repeat (2) @(posedge aclk);
                chk(irq, 1);
                wr(8'h10, 8'h00);
                rchk(8'h10, m);
                wr(8'h10, m);
                repeat (2) @(posedge aclk);
                chk(irq, 0);
                rchk(8'h10, 0);
            end
            $display("test irq done");
        end
    endtask
    // ----------
    // Main sequence and watchdog
    // ----------
    initial begin
        errors = 0;
        n_checks = 0;
        {aresetn, por_resetn, s_axi_awvalid, s_axi_wvalid} = 4'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {special_mode, debug_freeze, main_oscillator_clock} = 3'h0;
        {watch_crystal_clock, one_hz_comp_clock} = 2'h0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hf;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        ev = 5'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        por_resetn <= 1'b1;
        t_reset;
        t_protect;
        t_cfg;
        t_tick;
        t_irq;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        errors = errors + 1;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict;
    end
endmodule

// ---- verif/tkc_chk.sv ----
`timescale 1ns/100ps
module tkc_chk (
    // Clock and resets
    input wire        aclk,
    input wire        aresetn,
    input wire        por_resetn,
    // Bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Events and outputs
    input wire        hour_event,
    input wire        minute_event,
    input wire        second_event,
    input wire        correction_event,
    input wire        quarter_second_event,
    input wire        counter_run_enable,
    input wire        counter_tick,
    input wire        irq
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !por_resetn);
    // Any event pulse this cycle
    wire ev_any = hour_event | minute_event | second_event |
                  correction_event | quarter_second_event;
    run_gate_a: assert property (
        !counter_run_enable && !$past(counter_run_enable) &&
        !$past(counter_run_enable, 2) |-> !counter_tick)
        else $error("tick while stopped");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(ev_any, 2) || $past(s_axi_bvalid))
        else $error("irq rose without cause");
    irq_clear_a: assert property (
        $fell(irq) |-> $past(s_axi_bvalid))
        else $error("irq fell without write");
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
        $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata)) else $error("read data dropped");
    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    upper_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    bvalid_src_a: assert property (
        $rose(s_axi_bvalid) |-> !$past(s_axi_awready) &&
        !$past(s_axi_wready)) else $error("response without write");
    // Main scenarios reached
    cover property ($rose(irq));
    cover property (counter_tick);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule
bind tkc_control tkc_chk tkc_chk_i (.*);
